// file: hdl/mad_decoder.sv
// mad_decoder: address decoder between the processor external bus and board targets
// assumes bus strobes are one-cycle pulses on the bus clock, one access at a time
// Operation
// R1: standard variant maps data 8000H-FFFFH to sram pages 0-3 by page values 00H-03H, one wait.
// R2: small variant maps data 4000H-FFFFH to sram pages 0-1 by page values 00H-01H.
// R3: page values 80H-9FH map data 8000H-FFFFH to 32 flash pages, stretched to 120 ns.
// R4: overlay clear puts program page 0 at 0080H-FFFFH and page 1 at 10080H-1FFFFH, one wait.
// R5: standard variant with overlay set puts program pages at 8000H-FFFFH and 18000H-1FFFFH.
// R6: small variant with overlay set puts program pages at 4000H-FFFFH and 14000H-1FFFFH.
// R7: with overlay set the low program region is on-chip and never selects program sram.
// R8: while the data-rom bit is set on capable variants, data 8000H-FFFFH selects nothing; the code blocks it on the standard variant only.
// R9: i/o 0000H-007FH with the flag set selects the serial controller, 8 bits, 70 ns.
// R10: i/o 2000H-201FH with the flag set selects the usb controller, 8 bits, 74 ns.
// R11: on the standard variant software sets its wait register to 2209H or 2409H.
// R12: on the small variant software sets its wait register to 2249H or 2489H.
// R13: the page register holds a memory-type bit and page bits written at run time.
// R14: the page register resets to 80H in flash boot, else 00H, at i/o 8000H with the flag set.
// R15: the qualifying flag is the processor general-purpose flag output.
// R16: unmatched addresses select nothing; reads return zero and writes do nothing.
// R17: timed windows hold ready low for enough bus clock cycles to cover the access time.
`default_nettype none

module mad_decoder (
   input  wire  logic                clock,                 // bus clock, 100 MHz
   input  wire  logic                reset,                 // board reset, sync high
   input  wire  mad_pkg::mad_space_t bus_space,             // space of the access
   input  wire  logic [16:0]         bus_addr,              // word address
   input  wire  logic [7:0]          bus_wdata,             // write data d0..d7
   input  wire  logic                bus_wr,                // write strobe
   input  wire  logic                bus_rd,                // read strobe
   output var   logic [7:0]          bus_rdata,             // register read data
   output var   logic                bus_ready,             // processor ready
   input  wire  logic                program_overlay_bit,   // processor overlay bit
   input  wire  logic                data_rom_map_bit,      // processor data-rom bit
   input  wire  logic                external_flag_output,  // processor flag output
   input  wire  mad_pkg::mad_strap_t strap_pins,            // raw board straps
   output var   mad_pkg::mad_sel_t   mem_sel,               // target selects
   output var   logic [7:0]          data_page_select_reg   // page register state
);

   ////////////////////////////////////////////////////////////////////////////////
   // straps and wait timer

   mad_pkg::mad_strap_t strap_s;
   logic                busy;
   logic                last;

   mad_strap_sync #(
      .W        ($bits(mad_pkg::mad_strap_t))
   ) u_sync (
      .clock    (clock),
      .pin_in   (strap_pins),
      .sync_out (strap_s)
   );

   logic       acc;
   logic [3:0] dec_wait;

   mad_wait_timer u_timer (
      .clock    (clock),
      .reset    (reset),
      .load     (acc),
      .load_val (dec_wait),
      .busy     (busy),
      .last     (last)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // decode terms

   logic [7:0]  page_ff;
   logic [7:0]  nxt_page;
   wire  [15:0] low      = bus_addr[15:0];
   wire         a16      = bus_addr[16];
   wire         small_v  = strap_s.small_mem;

   // external base depends on on-chip memory size
   wire  [15:0] ext_base  = small_v ? mad_pkg::SMALL_EXT_BASE : mad_pkg::STD_EXT_BASE; // R1 R2
   // overlay moves program sram above on-chip region
   wire  [15:0] prog_base = program_overlay_bit ? ext_base : mad_pkg::PROG_LOW_BASE; // R4 R5 R6

   // program space
   wire hit_prog  = (bus_space == mad_pkg::SP_PROG) && (low >= prog_base); // R4 R5 R6 R7

   // data space: data-rom bit hands the top half to on-chip memory on the standard variant only
   wire rom_blk   = strap_s.rom_capable && data_rom_map_bit && !small_v; // R8
   wire is_data   = (bus_space == mad_pkg::SP_DATA) && !rom_blk; // R8
   wire flash_ty  = page_ff[mad_pkg::MEM_TYPE_POS]; // R13
   wire sram_pgok = small_v ? (page_ff[6:1] == 6'h00) : (page_ff[6:2] == 5'h00); // R1 R2
   wire hit_dsram = is_data && !flash_ty && sram_pgok && (low >= ext_base); // R1 R2
   wire hit_flash = is_data && flash_ty && (page_ff[6:5] == 2'h0)
                    && (low >= mad_pkg::STD_EXT_BASE); // R3

   // i/o space qualified by the processor flag
   wire io_ok     = (bus_space == mad_pkg::SP_IO) && external_flag_output; // R15
   wire hit_usart = io_ok && (low <= mad_pkg::USART_LAST); // R9
   wire hit_usb   = io_ok && (low >= mad_pkg::USB_BASE) && (low <= mad_pkg::USB_LAST); // R10
   wire hit_preg  = io_ok && (low == mad_pkg::PAGE_REG_ADDR); // R14

   ////////////////////////////////////////////////////////////////////////////////
   // decoded select set and wait figure

   mad_pkg::mad_sel_t dec;

   assign dec.prog_sram_cs   = hit_prog; // R4
   assign dec.prog_page      = hit_prog && a16; // page bits only beside their select
   assign dec.data_sram_cs   = hit_dsram; // R1
   assign dec.data_sram_page = !hit_dsram ? 2'h0 :
                               small_v ? {1'b0, page_ff[0]} : page_ff[1:0]; // R2
   assign dec.flash_cs       = hit_flash; // R3
   assign dec.flash_page     = hit_flash ? page_ff[4:0] : 5'h00;
   assign dec.usart_cs       = hit_usart; // R9
   assign dec.usb_cs         = hit_usb; // R10
   assign dec.page_reg_cs    = hit_preg;
   assign dec.byte_wide      = hit_usart || hit_usb || hit_preg; // R9 R10

   // wait cycles per target; no match means no select and no wait
   assign dec_wait = hit_flash ? mad_pkg::FLASH_WAIT : // R3 R17
                     hit_usart ? mad_pkg::USART_WAIT : // R9 R17
                     hit_usb   ? mad_pkg::USB_WAIT :   // R10 R17
                     hit_preg  ? mad_pkg::REG_WAIT :
                     (hit_prog || hit_dsram) ? mad_pkg::SRAM_WAIT : // R1 R4
                     mad_pkg::NO_WAIT; // R16

   // a strobe is taken only while idle
   assign acc = (bus_wr || bus_rd) && !busy;

   ////////////////////////////////////////////////////////////////////////////////
   // select hold: loaded at the strobe, dropped after the last wait cycle

   mad_pkg::mad_sel_t sel_ff;
   mad_pkg::mad_sel_t nxt_sel;

   assign nxt_sel = acc  ? dec : // R16
                    last ? mad_pkg::mad_sel_t'(0) : sel_ff;

   always_ff @(posedge clock) begin
      if (reset) begin
         sel_ff <= mad_pkg::mad_sel_t'(0);
      end else begin
         sel_ff <= nxt_sel;
      end
   end

   assign mem_sel   = sel_ff;
   assign bus_ready = !busy; // R17

   ////////////////////////////////////////////////////////////////////////////////
   // page-select register

   wire preg_wr  = acc && bus_wr && hit_preg; // R13
   wire preg_rd  = acc && bus_rd && hit_preg;
   wire [7:0] page_rst = (strap_s.boot_mode == mad_pkg::BOOT_FLASH) ?
                         mad_pkg::PAGE_RESET_FLASH : mad_pkg::PAGE_RESET_OTHER; // R14

   assign nxt_page = preg_wr ? bus_wdata : page_ff; // R13

   always_ff @(posedge clock) begin
      if (reset) begin
         page_ff <= page_rst; // R14
      end else begin
         page_ff <= nxt_page;
      end
   end

   assign data_page_select_reg = page_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // read data: register value one cycle after the strobe, zero otherwise

   logic [7:0] rdata_ff;
   wire  [7:0] nxt_rdata = preg_rd ? page_ff : 8'h00; // R16

   always_ff @(posedge clock) begin
      if (reset) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign bus_rdata = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // checks

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   wire strobe_idle = (bus_wr || bus_rd) && bus_ready;
   wire any_cs      = sel_ff.prog_sram_cs || sel_ff.data_sram_cs || sel_ff.flash_cs
                      || sel_ff.usart_cs || sel_ff.usb_cs || sel_ff.page_reg_cs;

   a_sram_std_page: assert property ( // R1
      strobe_idle && bus_space == mad_pkg::SP_DATA && !small_v && !rom_blk
      && page_ff <= 8'h03 && bus_addr[15] |=>
      sel_ff.data_sram_cs && sel_ff.data_sram_page == $past(page_ff[1:0]) && !bus_ready
      ##1 bus_ready && !sel_ff.data_sram_cs)
      else $error("data sram page select or one wait state wrong");

   a_sram_small_page: assert property ( // R2
      strobe_idle && bus_space == mad_pkg::SP_DATA && small_v
      && page_ff <= 8'h01 && bus_addr[15:14] != 2'h0 |=>
      sel_ff.data_sram_cs && sel_ff.data_sram_page == {1'b0, $past(page_ff[0])})
      else $error("small variant data sram page not selected");

   a_flash_window: assert property ( // R3
      strobe_idle && bus_space == mad_pkg::SP_DATA && !rom_blk
      && page_ff >= 8'h80 && page_ff <= 8'h9F && bus_addr[15] |=>
      (sel_ff.flash_cs && !bus_ready)[*6] ##1 (sel_ff.flash_cs && !bus_ready)[*6]
      ##1 (bus_ready && !sel_ff.flash_cs))
      else $error("flash window not held for 12 cycles");

   a_prog_low_map: assert property ( // R4
      strobe_idle && bus_space == mad_pkg::SP_PROG && !program_overlay_bit
      && bus_addr[15:0] >= 16'h0080 |=>
      sel_ff.prog_sram_cs && sel_ff.prog_page == $past(bus_addr[16]) && !bus_ready)
      else $error("program sram not selected with overlay clear");

   a_prog_program_overlay_bit_std: assert property ( // R5
      strobe_idle && bus_space == mad_pkg::SP_PROG && program_overlay_bit && !small_v
      |=> sel_ff.prog_sram_cs == $past(bus_addr[15]))
      else $error("standard overlay program map wrong");

   a_prog_program_overlay_bit_small: assert property ( // R6
      strobe_idle && bus_space == mad_pkg::SP_PROG && program_overlay_bit && small_v
      |=> sel_ff.prog_sram_cs == ($past(bus_addr[15:14]) != 2'h0))
      else $error("small overlay program map wrong");

   a_prog_onchip: assert property ( // R7
      strobe_idle && bus_space == mad_pkg::SP_PROG && program_overlay_bit
      && bus_addr[15:0] < 16'h4000 |=> !sel_ff.prog_sram_cs && bus_ready)
      else $error("on-chip program region selected external sram");

   a_rom_block: assert property ( // R8
      strobe_idle && bus_space == mad_pkg::SP_DATA && rom_blk
      |=> !sel_ff.data_sram_cs && !sel_ff.flash_cs)
      else $error("external data selected while data-rom bit set");

   a_usart_window: assert property ( // R9
      strobe_idle && bus_space == mad_pkg::SP_IO && external_flag_output
      && bus_addr[15:0] <= 16'h007F |=>
      (sel_ff.usart_cs && sel_ff.byte_wide && !bus_ready)[*7] ##1 bus_ready)
      else $error("serial controller window not 7 cycles");

   a_usb_window: assert property ( // R10
      strobe_idle && bus_space == mad_pkg::SP_IO && external_flag_output
      && bus_addr[15:5] == 11'h100 |=>
      (sel_ff.usb_cs && sel_ff.byte_wide && !bus_ready)[*8] ##1 bus_ready)
      else $error("usb controller window not 8 cycles");

   a_page_write: assert property ( // R13
      strobe_idle && bus_wr && bus_space == mad_pkg::SP_IO && external_flag_output
      && bus_addr[15:0] == 16'h8000 |=> page_ff == $past(bus_wdata))
      else $error("page register not written");

   a_page_readback: assert property ( // R14
      strobe_idle && bus_rd && hit_preg |=> bus_rdata == $past(page_ff))
      else $error("page register read data wrong");

   a_page_reset: assert property ( // R14
      @(posedge clock) disable iff (1'b0)
      $fell(reset) |-> page_ff == ((strap_s.boot_mode == mad_pkg::BOOT_FLASH) ? 8'h80 : 8'h00))
      else $error("page register reset value wrong");

   a_unmapped_quiet: assert property ( // R16
      strobe_idle && dec_wait == mad_pkg::NO_WAIT |=> !any_cs && bus_ready && bus_rdata == 8'h00)
      else $error("unmapped access selected a target");

   a_ready_tracks: assert property ( // R17
      !bus_ready |-> any_cs)
      else $error("ready held low with no target selected");

   c_flash_access: cover property (
      strobe_idle && hit_flash ##1 sel_ff.flash_cs[*6] ##1 sel_ff.flash_cs[*6] ##1 bus_ready);
   c_sram_back2back: cover property (
      strobe_idle && hit_dsram ##2 strobe_idle && hit_dsram);
   c_page_to_flash: cover property (
      preg_wr && bus_wdata[7] ##[2:5] strobe_idle && hit_flash);
   c_usb_access: cover property (
      strobe_idle && hit_usb);

endmodule : mad_decoder

`default_nettype wire

// file: hdl/mad_pkg.sv
// mad_pkg: constants, encodings and carriers of the memory and i/o address decoder
// assumes a single 100 MHz external bus clock shared with the processor bus
`default_nettype none

package mad_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // timing: access times in ns, converted to whole bus clock cycles (rounded up)
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned FLASH_TA_NS   = 120;
   localparam int unsigned USART_TA_NS   = 70;
   localparam int unsigned USB_TA_NS     = 74;
   localparam logic [3:0]  FLASH_WAIT    = 4'((FLASH_TA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]  USART_WAIT    = 4'((USART_TA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]  USB_WAIT      = 4'((USB_TA_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [3:0]  SRAM_WAIT     = 4'h1;
   localparam logic [3:0]  REG_WAIT      = 4'h2;
   localparam logic [3:0]  NO_WAIT       = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // address map (low 16 bits of the bus address)
   localparam logic [15:0] PROG_LOW_BASE  = 16'h0080;
   localparam logic [15:0] STD_EXT_BASE   = 16'h8000;
   localparam logic [15:0] SMALL_EXT_BASE = 16'h4000;
   localparam logic [15:0] USART_LAST     = 16'h007F;
   localparam logic [15:0] USB_BASE       = 16'h2000;
   localparam logic [15:0] USB_LAST       = 16'h201F;
   localparam logic [15:0] PAGE_REG_ADDR  = 16'h8000;

   ////////////////////////////////////////////////////////////////////////////////
   // page-select register layout and reset values
   localparam int unsigned MEM_TYPE_POS      = 7;
   localparam logic [7:0]  PAGE_RESET_FLASH  = 8'h80;
   localparam logic [7:0]  PAGE_RESET_OTHER  = 8'h00;

   // bus spaces, gray coded
   typedef enum logic [1:0] {
      SP_PROG = 2'h0,
      SP_DATA = 2'h1,
      SP_IO   = 2'h3
   } mad_space_t;

   // boot mode straps {sw2_2 off, sw2_1 off}
   typedef enum logic [1:0] {
      BOOT_NONE  = 2'h0,
      BOOT_HPI   = 2'h1,
      BOOT_FLASH = 2'h2,
      BOOT_RSVD  = 2'h3
   } mad_boot_t;

   typedef struct packed {
      logic       small_mem;     // small on-chip memory variant
      logic       rom_capable;   // variant whose data-rom bit can be set
      mad_boot_t  boot_mode;     // boot mode switches
   } mad_strap_t;

   typedef struct packed {
      logic       prog_sram_cs;   // program sram selected
      logic       prog_page;      // program sram page
      logic       data_sram_cs;   // data sram selected
      logic [1:0] data_sram_page; // data sram page
      logic       flash_cs;       // flash selected
      logic [4:0] flash_page;     // flash page
      logic       usart_cs;       // serial controller selected
      logic       usb_cs;         // usb controller selected
      logic       page_reg_cs;    // page-select register accessed
      logic       byte_wide;      // only d0..d7 carried
   } mad_sel_t;

endpackage : mad_pkg

`default_nettype wire

// file: hdl/mad_strap_sync.sv
// mad_strap_sync: three-stage synchroniser for slow board straps
// assumes straps are static; output updates when stages two and three agree
`default_nettype none

module mad_strap_sync #(
   parameter int unsigned W = 4
) (
   input  wire  logic         clock,    // bus clock
   input  wire  logic [W-1:0] pin_in,   // raw strap pins
   output var   logic [W-1:0] sync_out  // filtered strap value
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] s2_ff;
   logic [W-1:0] s3_ff;
   logic [W-1:0] out_ff;
   wire          agree = (s2_ff == s3_ff);

   ////////////////////////////////////////////////////////////////////////////////
   // data-only chain, no reset so straps settle while board reset is held
   always_ff @(posedge clock) begin
      meta_ff <= pin_in;
      s2_ff   <= meta_ff;
      s3_ff   <= s2_ff;
      if (agree) begin
         out_ff <= s3_ff;
      end
   end

   assign sync_out = out_ff;

endmodule : mad_strap_sync

`default_nettype wire

// file: hdl/mad_wait_timer.sv
// mad_wait_timer: down counter holding processor ready low for an access
// assumes load only while idle; a zero load leaves it idle
`default_nettype none

module mad_wait_timer (
   input  wire  logic       clock,    // bus clock
   input  wire  logic       reset,    // synchronous, active high
   input  wire  logic       load,     // start of access
   input  wire  logic [3:0] load_val, // wait cycles
   output var   logic       busy,     // access in progress
   output var   logic       last      // final wait cycle
);

   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;

   // next count: load, else count down to zero
   assign nxt_cnt = load ? load_val : ((cnt_ff != 4'h0) ? cnt_ff - 4'h1 : 4'h0);
   assign busy    = (cnt_ff != 4'h0);
   assign last    = (cnt_ff == 4'h1);

   always_ff @(posedge clock) begin
      if (reset) begin
         cnt_ff <= 4'h0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

endmodule : mad_wait_timer

`default_nettype wire

// file: test/mad_cpu_model.sv
// mad_cpu_model: processor side of the external bus, one access at a time
// assumes one bench process calls its tasks; the decoder never stalls a strobe
`default_nettype none

module mad_cpu_model (
   input  wire  logic                clock,                 // bus clock
   input  wire  logic                small_variant,         // small on-chip memory part
   output var   mad_pkg::mad_space_t bus_space,             // access space
   output var   logic [16:0]         bus_addr,              // word address
   output var   logic [7:0]          bus_wdata,             // write data
   output var   logic                bus_wr,                // write strobe
   output var   logic                bus_rd,                // read strobe
   output var   logic                program_overlay_bit,   // overlay bit
   output var   logic                data_rom_map_bit,      // data-rom bit
   output var   logic                external_flag_output,  // general-purpose flag
   input  wire  logic                bus_ready,             // ready from decoder
   input  wire  logic [7:0]          bus_rdata,             // read data
   input  wire  mad_pkg::mad_sel_t   mem_sel                // target selects
);
   timeunit 1ns;
   timeprecision 1ns;

   logic [15:0] software_wait_state_reg; // wait setting software would keep

   ////////////////////////////////////////////////////////////////////////////////
   // idle bus at time zero
   initial begin
      bus_space               = mad_pkg::SP_DATA;
      bus_addr                = 17'h00000;
      bus_wdata               = 8'h00;
      bus_wr                  = 1'h0;
      bus_rd                  = 1'h0;
      program_overlay_bit     = 1'h0;
      data_rom_map_bit        = 1'h0;
      external_flag_output    = 1'h1;
      software_wait_state_reg = 16'h2209;
   end

   // status bits change only just after an edge
   task automatic set_mode(input logic ovl, input logic rom_on, input logic flag);
      @(posedge clock);
      program_overlay_bit  <= ovl;
      data_rom_map_bit     <= rom_on;
      external_flag_output <= flag;
   endtask : set_mode

   // one strobe cycle, then count the cycles that ready stays low
   task automatic access(input mad_pkg::mad_space_t sp, input logic [16:0] ad,
                         input logic wr, input logic [7:0] wd,
                         output mad_pkg::mad_sel_t sel, output logic [7:0] rd,
                         output int waits);
      @(posedge clock);
      bus_space <= sp;
      bus_addr  <= ad;
      bus_wdata <= wd;
      bus_wr    <= wr;
      bus_rd    <= ~wr;
      @(posedge clock);
      bus_wr    <= 1'h0;
      bus_rd    <= 1'h0;
      bus_addr  <= ~ad; // released lines must not keep the last value
      bus_wdata <= ~wd;
      #1;
      sel   = mem_sel;
      rd    = bus_rdata;
      waits = 0;
      while (bus_ready !== 1'h1 && waits < 40) begin
         waits++;
         @(posedge clock);
         #1;
      end
      // reprogram the wait setting whenever the memory type is written
      if (wr && sp == mad_pkg::SP_IO && ad[15:0] == mad_pkg::PAGE_REG_ADDR) begin
         software_wait_state_reg = small_variant ? (wd[7] ? 16'h2489 : 16'h2249)
                                                 : (wd[7] ? 16'h2409 : 16'h2209);
      end
   endtask : access

endmodule : mad_cpu_model

`default_nettype wire

// file: test/mad_decoder_bench.sv
// mad_decoder_bench: self-checking bench for the address decoder
// assumes the processor model drives the bus; straps change only under reset
`default_nettype none

module mad_decoder_bench;
   timeunit 1ns;
   timeprecision 1ns;

   localparam int K_NONE = 0;
   localparam int K_PROG = 1;
   localparam int K_DSR  = 2;
   localparam int K_FLS  = 3;
   localparam int K_USA  = 4;
   localparam int K_USB  = 5;
   localparam int K_REG  = 6;
   localparam mad_pkg::mad_space_t PRG = mad_pkg::SP_PROG;
   localparam mad_pkg::mad_space_t DAT = mad_pkg::SP_DATA;
   localparam mad_pkg::mad_space_t IOS = mad_pkg::SP_IO;
   localparam logic [3:0]          WS  = mad_pkg::SRAM_WAIT;
   localparam logic [3:0]          WF  = mad_pkg::FLASH_WAIT;

   logic                clock;
   logic                reset;
   mad_pkg::mad_space_t bus_space;
   logic [16:0]         bus_addr;
   logic [7:0]          bus_wdata;
   logic                bus_wr;
   logic                bus_rd;
   logic [7:0]          bus_rdata;
   logic                bus_ready;
   logic                ovl;
   logic                rom_on;
   logic                flag;
   mad_pkg::mad_strap_t strap_pins;
   mad_pkg::mad_sel_t   mem_sel;
   logic [7:0]          page;
   logic [7:0]          last_rd;
   int                  miscompares;
   int                  cmp_count;

   mad_decoder mad_decoder_i (
      .clock(clock), .reset(reset), .bus_space(bus_space), .bus_addr(bus_addr),
      .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
      .bus_ready(bus_ready), .program_overlay_bit(ovl), .data_rom_map_bit(rom_on),
      .external_flag_output(flag), .strap_pins(strap_pins), .mem_sel(mem_sel),
      .data_page_select_reg(page));

   mad_cpu_model mad_cpu_model_i (
      .clock(clock), .small_variant(strap_pins.small_mem), .bus_space(bus_space),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .program_overlay_bit(ovl), .data_rom_map_bit(rom_on), .external_flag_output(flag),
      .bus_ready(bus_ready), .bus_rdata(bus_rdata), .mem_sel(mem_sel));

   ////////////////////////////////////////////////////////////////////////////////
   // clock, 10 ns period
   initial begin
      clock = 1'h0;
      forever #5 clock = ~clock;
   end

   // verdict and end of run
   task automatic stop_test;
      if (miscompares == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   task automatic chk_num(input string name, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", name, exp, got);
      end
   endtask : chk_num

   task automatic chk_sel(input mad_pkg::mad_sel_t exp, input mad_pkg::mad_sel_t got);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD selects expected %h seen %h", exp, got);
      end
   endtask : chk_sel

   // expected select word for a target kind and page
   function automatic mad_pkg::mad_sel_t mk(input int k, input logic [4:0] pg);
      mad_pkg::mad_sel_t s;
      s = '0;
      case (k)
         K_PROG: begin s.prog_sram_cs = 1'h1; s.prog_page = pg[0]; end
         K_DSR:  begin s.data_sram_cs = 1'h1; s.data_sram_page = pg[1:0]; end
         K_FLS:  begin s.flash_cs = 1'h1; s.flash_page = pg; end
         K_USA:  begin s.usart_cs = 1'h1; s.byte_wide = 1'h1; end
         K_USB:  begin s.usb_cs = 1'h1; s.byte_wide = 1'h1; end
         K_REG:  begin s.page_reg_cs = 1'h1; s.byte_wide = 1'h1; end
         default: s = '0;
      endcase
      return s;
   endfunction : mk

   // one access with expected target and wait count; defaults make an unmapped read
   task automatic acc(input mad_pkg::mad_space_t sp, input logic [16:0] ad,
                      input int k = K_NONE, input logic [4:0] pg = 5'h00,
                      input logic [3:0] nw = 4'h0, input logic wr = 1'h0,
                      input logic [7:0] wd = 8'h00);
      mad_pkg::mad_sel_t sel;
      logic [7:0]        rd;
      int                w;
      mad_cpu_model_i.access(sp, ad, wr, wd, sel, rd, w);
      chk_sel(mk(k, pg), sel);
      chk_num("wait cycles", {4'h0, nw}, 8'(w));
      last_rd = rd;
   endtask : acc

   task automatic wr_page(input logic [7:0] v);
      acc(IOS, 17'h08000, K_REG, 5'h00, mad_pkg::REG_WAIT, 1'h1, v);
      chk_num("page register", v, page);
   endtask : wr_page

   task automatic do_reset(input logic sm, input logic cap, input mad_pkg::mad_boot_t bm);
      @(posedge clock);
      reset      <= 1'h1;
      strap_pins <= '{sm, cap, bm};
      repeat (6) @(posedge clock);
      reset <= 1'h0;
      #1;
      chk_num("page reset", (bm == mad_pkg::BOOT_FLASH) ? 8'h80 : 8'h00, page);
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////////
   // hang guard
   initial begin
      repeat (4000) @(posedge clock);
      miscompares++;
      stop_test;
   end

   // main sequence
   initial begin
      reset       = 1'h1;
      strap_pins  = '{1'h0, 1'h1, mad_pkg::BOOT_FLASH};
      miscompares = 0;
      cmp_count   = 0;
      do_reset(1'h0, 1'h1, mad_pkg::BOOT_FLASH);
      acc(DAT, 17'h08000, K_FLS, 5'h00, WF);
      wr_page(8'h9F);
      acc(DAT, 17'h0FFFF, K_FLS, 5'h1F, WF, 1'h1, 8'h5A);
      for (int p = 0; p < 4; p++) begin
         wr_page(8'(p));
         acc(DAT, 17'h0C000, K_DSR, 5'(p), WS);
      end
      wr_page(8'h04);
      acc(DAT, 17'h08000);
      chk_num("unmapped rdata", 8'h00, last_rd);
      acc(IOS, 17'h08000, K_REG, 5'h00, mad_pkg::REG_WAIT);
      chk_num("page rdata", 8'h04, last_rd);
      mad_cpu_model_i.set_mode(1'h0, 1'h0, 1'h0);
      acc(IOS, 17'h08000, K_NONE, 5'h00, 4'h0, 1'h1, 8'h01);
      chk_num("page kept", 8'h04, page);
      acc(IOS, 17'h00000);
      mad_cpu_model_i.set_mode(1'h0, 1'h1, 1'h1);
      wr_page(8'h00);
      acc(DAT, 17'h08000);
      mad_cpu_model_i.set_mode(1'h0, 1'h0, 1'h1);
      acc(DAT, 17'h07FFF);
      acc(PRG, 17'h00080, K_PROG, 5'h00, WS);
      acc(PRG, 17'h0007F);
      acc(PRG, 17'h10080, K_PROG, 5'h01, WS);
      mad_cpu_model_i.set_mode(1'h1, 1'h0, 1'h1);
      acc(PRG, 17'h07FFF);
      acc(PRG, 17'h08000, K_PROG, 5'h00, WS);
      acc(PRG, 17'h18000, K_PROG, 5'h01, WS);
      acc(PRG, 17'h17FFF);
      acc(IOS, 17'h00000, K_USA, 5'h00, mad_pkg::USART_WAIT, 1'h1, 8'h3C);
      acc(IOS, 17'h0007F, K_USA, 5'h00, mad_pkg::USART_WAIT);
      acc(IOS, 17'h00080);
      acc(IOS, 17'h02000, K_USB, 5'h00, mad_pkg::USB_WAIT, 1'h1, 8'hC3);
      acc(IOS, 17'h0201F, K_USB, 5'h00, mad_pkg::USB_WAIT);
      acc(IOS, 17'h02020);
      do_reset(1'h1, 1'h0, mad_pkg::BOOT_HPI);
      acc(DAT, 17'h04000, K_DSR, 5'h00, WS);
      wr_page(8'h01);
      acc(DAT, 17'h0FFFF, K_DSR, 5'h01, WS);
      wr_page(8'h02);
      acc(DAT, 17'h04000);
      wr_page(8'h85);
      acc(DAT, 17'h08000, K_FLS, 5'h05, WF);
      acc(PRG, 17'h03FFF);
      acc(PRG, 17'h04000, K_PROG, 5'h00, WS);
      acc(PRG, 17'h14000, K_PROG, 5'h01, WS);
      stop_test;
   end

endmodule : mad_decoder_bench

`default_nettype wire
